// ### deadman_timer_status_readback.sv
/*
 * Deadman timer: key sequence, status flags, live count readback,
 * upper-count snapshot and fuse mirrors, behind an APB slave.
 * Assumes fuse words are stable from reset release onward and
 * fetch_strobe is a one-cycle pulse per instruction fetch.
 */
`timescale 1ns/1ps
`default_nettype none

module deadman_timer_status_readback #(
    parameter int CNT_W = deadman_pkg::CNT_W
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [deadman_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [deadman_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [deadman_pkg::DATA_W-1:0]   prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             fetch_strobe,
    input  wire logic [deadman_pkg::HALF_W-1:0]   fuse_timeout_low,
    input  wire logic [deadman_pkg::HALF_W-1:0]   fuse_timeout_high,
    input  wire logic [deadman_pkg::HALF_W-1:0]   fuse_window_low,
    input  wire logic [deadman_pkg::HALF_W-1:0]   fuse_window_high,
    input  wire logic                             fuse_timer_disable,
    output logic                                  timeout_event_pulse
);

    deadman_pkg::status_state_t q;
    deadman_pkg::status_state_t d;

    logic [CNT_W-1:0] count;
    logic             expired;
    logic             restart;
    logic             timer_on;
    logic             window_open;
    logic             setup;
    logic             wr_done;
    logic             rd_setup;
    logic             wr_pre;
    logic             wr_clr;
    logic             good_pre;
    logic             good_clr;

    // ==========================================================
    // Address decode
    function automatic logic hit(
        input logic [deadman_pkg::ADDR_W-1:0] addr,
        input logic [deadman_pkg::ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction : hit

    function automatic logic mapped(
        input logic [deadman_pkg::ADDR_W-1:0] addr
    );
        mapped = hit(addr, deadman_pkg::OFF_CONTROL)
               | hit(addr, deadman_pkg::OFF_PRECLEAR)
               | hit(addr, deadman_pkg::OFF_CLEAR)
               | hit(addr, deadman_pkg::OFF_STATUS)
               | hit(addr, deadman_pkg::OFF_COUNT_LO)
               | hit(addr, deadman_pkg::OFF_COUNT_HI)
               | hit(addr, deadman_pkg::OFF_CFGCNT_LO)
               | hit(addr, deadman_pkg::OFF_CFGCNT_HI)
               | hit(addr, deadman_pkg::OFF_CFGWIN_LO)
               | hit(addr, deadman_pkg::OFF_CFGWIN_HI)
               | hit(addr, deadman_pkg::OFF_SNAPSHOT);
    endfunction : mapped

    // ==========================================================
    // Bus phases and key checks
    assign setup    = psel && !penable;
    assign wr_done  = psel && penable && q.pready && pwrite;
    assign rd_setup = setup && !pwrite;
    assign wr_pre   = wr_done && hit(paddr, deadman_pkg::OFF_PRECLEAR)
                      && pstrb[deadman_pkg::PRE_LANE];
    assign wr_clr   = wr_done && hit(paddr, deadman_pkg::OFF_CLEAR)
                      && pstrb[deadman_pkg::CLR_LANE];
    assign good_pre = wr_pre && (pwdata[deadman_pkg::PRE_KEY_LSB +:
                      deadman_pkg::KEY_W] == deadman_pkg::PRECLEAR_KEY);
    // Clear key counts only once the preclear key is armed
    assign good_clr = wr_clr
                      && (q.pre_key == deadman_pkg::PRECLEAR_KEY)
                      && (pwdata[deadman_pkg::CLR_KEY_LSB +:
                          deadman_pkg::KEY_W] == deadman_pkg::CLEAR_KEY);
    assign restart  = good_clr;

    // Fuse disable hands control to nothing: timer stays off
    assign timer_on    = q.on && !q.fuse_dis;
    assign window_open = timer_on && (count >= q.cfg_window);

    // ==========================================================
    // Counter
    deadman_counter #(
        .CNT_W (CNT_W)
    ) u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (timer_on),
        .advance (fetch_strobe),
        .restart (restart),
        .limit   (q.cfg_count),
        .count   (count),
        .expired (expired)
    );

    // ==========================================================
    // Next state
    always_comb begin
        d         = q;
        d.pready  = setup;
        d.pslverr = setup && !mapped(paddr);
        d.pulse   = 1'b0;

        // Fuses caught on the first edge after reset release
        if (!q.cfg_loaded) begin
            d.cfg_loaded = 1'b1;
            d.fuse_dis   = fuse_timer_disable;
            d.cfg_count  = {fuse_timeout_high, fuse_timeout_low};
            d.cfg_window = {fuse_window_high, fuse_window_low};
        end

        // Read data is taken in the setup cycle, held through access
        if (rd_setup) begin
            d.prdata = deadman_pkg::RST_DATA;
            case (1'b1)
                hit(paddr, deadman_pkg::OFF_CONTROL): begin
                    d.prdata[deadman_pkg::ON_BIT] = q.on;
                end
                hit(paddr, deadman_pkg::OFF_PRECLEAR): begin
                    d.prdata[deadman_pkg::PRE_KEY_LSB +:
                             deadman_pkg::KEY_W] = q.pre_key;
                end
                hit(paddr, deadman_pkg::OFF_CLEAR): begin
                    d.prdata[deadman_pkg::CLR_KEY_LSB +:
                             deadman_pkg::KEY_W] = q.clr_key;
                end
                hit(paddr, deadman_pkg::OFF_STATUS): begin
                    d.prdata[deadman_pkg::BAD_PRE_BIT] = q.bad_pre;
                    d.prdata[deadman_pkg::BAD_CLR_BIT] = q.bad_clr;
                    d.prdata[deadman_pkg::EVENT_BIT]   = q.event_flag;
                    d.prdata[deadman_pkg::WIN_BIT]     = window_open;
                end
                hit(paddr, deadman_pkg::OFF_COUNT_LO): begin
                    d.prdata[15:0] = count[15:0];
                    d.hold         = count[31:16];
                end
                hit(paddr, deadman_pkg::OFF_COUNT_HI): begin
                    d.prdata[15:0] = count[31:16];
                    d.hold         = count[31:16];
                end
                hit(paddr, deadman_pkg::OFF_CFGCNT_LO): begin
                    d.prdata[15:0] = q.cfg_count[15:0];
                end
                hit(paddr, deadman_pkg::OFF_CFGCNT_HI): begin
                    d.prdata[15:0] = q.cfg_count[31:16];
                end
                hit(paddr, deadman_pkg::OFF_CFGWIN_LO): begin
                    d.prdata[15:0] = q.cfg_window[15:0];
                end
                hit(paddr, deadman_pkg::OFF_CFGWIN_HI): begin
                    d.prdata[15:0] = q.cfg_window[31:16];
                end
                hit(paddr, deadman_pkg::OFF_SNAPSHOT): begin
                    d.prdata[15:0] = q.hold;
                end
                default: begin
                    d.prdata = deadman_pkg::RST_DATA;
                end
            endcase
        end

        // Writes land at the completing edge only
        if (wr_done && hit(paddr, deadman_pkg::OFF_CONTROL)
            && pstrb[deadman_pkg::PRE_LANE]) begin
            d.on = pwdata[deadman_pkg::ON_BIT];
        end
        if (wr_pre) begin
            d.pre_key = pwdata[deadman_pkg::PRE_KEY_LSB +:
                               deadman_pkg::KEY_W];
            if (!good_pre) begin
                d.bad_pre = 1'b1;
            end
        end
        if (wr_clr) begin
            if (good_clr) begin
                // Good sequence wipes keys and the bad-key history
                d.pre_key = deadman_pkg::RST_KEY;
                d.clr_key = deadman_pkg::RST_KEY;
                d.bad_pre = 1'b0;
                d.bad_clr = 1'b0;
            end else begin
                d.clr_key = pwdata[deadman_pkg::CLR_KEY_LSB +:
                                   deadman_pkg::KEY_W];
                d.bad_clr = 1'b1;
            end
        end

        // Event is sticky; software has no path to clear it
        if (expired || (wr_pre && !good_pre)
            || (wr_clr && !good_clr)) begin
            d.event_flag = 1'b1;
            d.pulse      = !q.event_flag;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.pre_key <= deadman_pkg::RST_KEY;
            q.hold    <= deadman_pkg::RST_HALF;
        end else begin
            q <= d;
        end
    end

    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign timeout_event_pulse = q.pulse;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_read_lo;
        rd_setup && hit(paddr, deadman_pkg::OFF_COUNT_LO);
    endsequence

    sequence s_read_hi;
        rd_setup && hit(paddr, deadman_pkg::OFF_COUNT_HI);
    endsequence

    sequence s_armed_clear;
        wr_clr && (q.pre_key == deadman_pkg::PRECLEAR_KEY)
        && (pwdata[7:0] == deadman_pkg::CLEAR_KEY);
    endsequence

    sequence s_all_restarted;
        (count == deadman_pkg::RST_COUNT)
        && (q.pre_key == deadman_pkg::RST_KEY)
        && (q.clr_key == deadman_pkg::RST_KEY);
    endsequence

    property p_clear_restarts;
        s_armed_clear |=> s_all_restarted;
    endproperty

    a_bad_preclear_set: assert property (
        wr_pre && (pwdata[15:8] != deadman_pkg::PRECLEAR_KEY)
        |=> q.bad_pre && q.event_flag)
        else $error("bad preclear key not flagged");

    a_bad_clear_set: assert property (
        wr_clr && !good_clr
        |=> q.bad_clr && (q.clr_key == $past(pwdata[7:0]))
            && $stable(q.pre_key))
        else $error("bad clear key not flagged or captured");

    a_expiry_event: assert property (
        expired |=> q.event_flag)
        else $error("expiry did not raise the event flag");

    a_event_sticky: assert property (
        q.event_flag |=> q.event_flag)
        else $error("event flag fell without reset");

    a_status_window: assert property (
        rd_setup && hit(paddr, deadman_pkg::OFF_STATUS)
        |=> prdata[0] == $past(window_open) && pready)
        else $error("window bit misreported");

    a_count_low_read: assert property (
        s_read_lo |=> (prdata[15:0] == $past(count[15:0]))
                      && (prdata[31:16] == 16'h0000) && pready)
        else $error("low count read wrong");

    a_count_high_read: assert property (
        s_read_hi |=> (prdata[15:0] == $past(count[31:16]))
                      && (prdata[31:16] == 16'h0000))
        else $error("high count read wrong");

    a_fuse_count_load: assert property (
        $rose(q.cfg_loaded) |-> q.cfg_count
            == $past({fuse_timeout_high, fuse_timeout_low})
            ##1 $stable(q.cfg_count)[*4])
        else $error("fuse count not mirrored");

    a_fuse_window_load: assert property (
        q.cfg_loaded |=> $stable(q.cfg_window))
        else $error("window mirror changed");

    a_hold_capture: assert property (
        s_read_lo or s_read_hi |=> q.hold == $past(count[31:16]))
        else $error("snapshot missed a count read");

    a_hold_quiet: assert property (
        !(rd_setup && (hit(paddr, deadman_pkg::OFF_COUNT_LO)
          || hit(paddr, deadman_pkg::OFF_COUNT_HI)))
        |=> $stable(q.hold))
        else $error("snapshot changed without a count read");

    a_count_on_fetch: assert property (
        !fetch_strobe && !restart |=> $stable(count))
        else $error("counter moved without a fetch");

    a_preclear_arm: assert property (
        good_pre |=> q.pre_key == deadman_pkg::PRECLEAR_KEY)
        else $error("preclear key not armed");

    a_clear_restart: assert property (
        p_clear_restarts)
        else $error("clear sequence did not restart the timer");

    a_fuse_gate: assert property (
        q.fuse_dis && !restart |=> $stable(count))
        else $error("timer ran while fuse-disabled");

    a_event_pulse: assert property (
        $rose(q.event_flag) |-> q.pulse ##1 !q.pulse)
        else $error("event pulse not single-cycle");

endmodule : deadman_timer_status_readback

`default_nettype wire

// ### deadman_pkg.sv
/*
 * Constants and state types for the deadman timer status block.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package deadman_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 32;
    localparam int HALF_W = 16;
    localparam int KEY_W  = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL    = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_PRECLEAR   = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CLEAR      = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_STATUS     = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_COUNT_LO   = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HI   = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_CFGCNT_LO  = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_CFGCNT_HI  = 12'h01c;
    localparam logic [ADDR_W-1:0] OFF_CFGWIN_LO  = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_CFGWIN_HI  = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_SNAPSHOT   = 12'h028;

    // ==========================================================
    // Field positions
    localparam int ON_BIT       = 15;
    localparam int PRE_KEY_LSB  = 8;
    localparam int CLR_KEY_LSB  = 0;
    localparam int BAD_PRE_BIT  = 7;
    localparam int BAD_CLR_BIT  = 6;
    localparam int EVENT_BIT    = 5;
    localparam int WIN_BIT      = 0;
    localparam int PRE_LANE     = 1;
    localparam int CLR_LANE     = 0;

    // ==========================================================
    // Keys and reset values
    localparam logic [KEY_W-1:0]  PRECLEAR_KEY = 8'h40;
    localparam logic [KEY_W-1:0]  CLEAR_KEY    = 8'h08;
    localparam logic [KEY_W-1:0]  RST_KEY      = 8'h00;
    localparam logic [HALF_W-1:0] RST_HALF     = 16'h0000;
    localparam logic [CNT_W-1:0]  RST_COUNT    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_DATA     = 32'h0000_0000;

    // ==========================================================
    // State types
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             expired;
    } counter_state_t;

    typedef struct packed {
        logic              on;
        logic [KEY_W-1:0]  pre_key;
        logic [KEY_W-1:0]  clr_key;
        logic              bad_pre;
        logic              bad_clr;
        logic              event_flag;
        logic [HALF_W-1:0] hold;
        logic              cfg_loaded;
        logic              fuse_dis;
        logic [CNT_W-1:0]  cfg_count;
        logic [CNT_W-1:0]  cfg_window;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
        logic              pulse;
    } status_state_t;

endpackage : deadman_pkg

// ### deadman_counter.sv
/*
 * Instruction fetch counter of the deadman timer.
 * Assumes advance pulses once per fetch, in the pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module deadman_counter #(
    parameter int CNT_W = deadman_pkg::CNT_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic             advance,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] limit,
    output logic      [CNT_W-1:0] count,
    output logic                  expired
);

    deadman_pkg::counter_state_t q;
    deadman_pkg::counter_state_t d;

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        if (restart) begin
            d.count   = deadman_pkg::RST_COUNT;
            d.expired = 1'b0;
        end else if (enable && !q.expired) begin
            // Stops on match so the expiry cannot wrap away
            if (q.count == limit) begin
                d.expired = 1'b1;
            end else if (advance) begin
                d.count = q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count   = q.count;
    assign expired = q.expired;

endmodule : deadman_counter

`default_nettype wire

// ### deadman_timer_status_readback_tb.sv
/*
 * Self-checking bench for the deadman timer status block: APB tasks,
 * fetch pulses and register sequences with expected values.
 * Assumes the zero-wait APB slave and fuse capture described for the DUT.
 */
`timescale 1ns/1ps
`default_nettype none

module deadman_timer_status_readback_tb;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fetch_strobe;
    logic [15:0] fuse_timeout_low;
    logic [15:0] fuse_timeout_high;
    logic [15:0] fuse_window_low;
    logic [15:0] fuse_window_high;
    logic        fuse_timer_disable;
    logic        timeout_event_pulse;
    logic [31:0] rd_data;
    logic        rd_err;
    int          err_total;
    int          total_checks;
    int          pulse_total;

    deadman_timer_status_readback DUT (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .pstrb               (pstrb),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .fetch_strobe        (fetch_strobe),
        .fuse_timeout_low    (fuse_timeout_low),
        .fuse_timeout_high   (fuse_timeout_high),
        .fuse_window_low     (fuse_window_low),
        .fuse_window_high    (fuse_window_high),
        .fuse_timer_disable  (fuse_timer_disable),
        .timeout_event_pulse (timeout_event_pulse)
    );

    // ==========================================================
    // Clock, pulse monitor, watchdog
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (timeout_event_pulse === 1'b1) begin
            pulse_total <= pulse_total + 1;
        end
    end

    // Run needs about 66k cycles; margin before the cut
    initial begin
        repeat (90000) @(posedge pclk);
        err_total++;
        complete_run();
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] data);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            $display("BAD t=%0t no bus answer", $time);
        end
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd_data, exp);
        check({31'h0, rd_err}, 32'h0000_0000);
    endtask : rd_chk

    task automatic fetch(input int n);
        repeat (n) begin
            fetch_strobe <= 1'b1;
            @(posedge pclk);
        end
        fetch_strobe <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : fetch

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Main sequence
    initial begin
        presetn            = 1'b0;
        psel               = 1'b0;
        penable            = 1'b0;
        pwrite             = 1'b0;
        paddr              = 12'h000;
        pwdata             = 32'h0000_0000;
        pstrb              = 4'hf;
        fetch_strobe       = 1'b0;
        fuse_timeout_low   = 16'h0004;
        fuse_timeout_high  = 16'h0001;
        fuse_window_low    = 16'h0008;
        fuse_window_high   = 16'h0000;
        fuse_timer_disable = 1'b0;
        err_total          = 0;
        total_checks       = 0;
        pulse_total        = 0;
        @(posedge pclk);
        do_reset();
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_COUNT_HI, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_SNAPSHOT, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_CFGCNT_LO, 32'h0000_0004);
        rd_chk(deadman_pkg::OFF_CFGCNT_HI, 32'h0000_0001);
        rd_chk(deadman_pkg::OFF_CFGWIN_LO, 32'h0000_0008);
        rd_chk(deadman_pkg::OFF_CFGWIN_HI, 32'h0000_0000);
        // Read-only places must ignore writes
        apb(1'b1, deadman_pkg::OFF_STATUS, 32'h0000_ffff);
        apb(1'b1, deadman_pkg::OFF_CFGWIN_LO, 32'h0000_ffff);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_CFGWIN_LO, 32'h0000_0008);
        apb(1'b0, 12'h100, 32'h0000_0000);
        check({31'h0, rd_err}, 32'h0000_0001);
        check(rd_data, 32'h0000_0000);
        // Counting and clear window
        apb(1'b1, deadman_pkg::OFF_CONTROL, 32'h0000_8000);
        fetch(5);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0005);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0000);
        fetch(4);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0001);
        // Wrong preclear key, then wrong clear key after a good preclear
        apb(1'b1, deadman_pkg::OFF_PRECLEAR, 32'h0000_1200);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_00a1);
        check(pulse_total, 32'h0000_0001);
        apb(1'b1, deadman_pkg::OFF_PRECLEAR, 32'h0000_4000);
        apb(1'b1, deadman_pkg::OFF_CLEAR, 32'h0000_0055);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_00e1);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0009);
        // Good sequence restarts the counter; event stays sticky
        apb(1'b1, deadman_pkg::OFF_PRECLEAR, 32'h0000_4000);
        apb(1'b1, deadman_pkg::OFF_CLEAR, 32'h0000_0008);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0020);
        // Run past the 0x1_0004 limit; counter must stop there
        fetch(65550);
        rd_chk(deadman_pkg::OFF_SNAPSHOT, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0004);
        rd_chk(deadman_pkg::OFF_SNAPSHOT, 32'h0000_0001);
        rd_chk(deadman_pkg::OFF_COUNT_HI, 32'h0000_0001);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0021);
        check(pulse_total, 32'h0000_0001);
        // Fuse disable overrides the software enable
        fuse_timer_disable <= 1'b1;
        do_reset();
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0000);
        rd_chk(deadman_pkg::OFF_SNAPSHOT, 32'h0000_0000);
        apb(1'b1, deadman_pkg::OFF_CONTROL, 32'h0000_8000);
        fetch(3);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0000);
        // Short fuse count: expiry alone raises the event and one pulse
        fuse_timer_disable <= 1'b0;
        fuse_timeout_low   <= 16'h0003;
        fuse_timeout_high  <= 16'h0000;
        do_reset();
        rd_chk(deadman_pkg::OFF_CFGCNT_LO, 32'h0000_0003);
        rd_chk(deadman_pkg::OFF_CFGCNT_HI, 32'h0000_0000);
        apb(1'b1, deadman_pkg::OFF_CONTROL, 32'h0000_8000);
        fetch(6);
        rd_chk(deadman_pkg::OFF_COUNT_LO, 32'h0000_0003);
        rd_chk(deadman_pkg::OFF_STATUS, 32'h0000_0020);
        check(pulse_total, 32'h0000_0002);
        complete_run();
    end

endmodule : deadman_timer_status_readback_tb

`default_nettype wire
